/* File: bench/pll_config_registers_sva.sv */
// Port-level assertions for the loop configuration register group.
`timescale 1ns/1ns
`include "pll_config_regs.vh"
module pll_config_registers_sva (
   input wire core_clk, rst, soft_reset, wr_en, phase_detector_invert,
   input wire [`ADDR_W-1:0] wr_addr,
   input wire [7:0] wr_data,
   input wire [15:0] user_version_tag,
   input wire [2:0] charge_pump_current,
   input wire [5:0] charge_pump_current_ua_div100, feedback_a_count,
   input wire [1:0] charge_pump_mode,
   input wire charge_pump_high_z, charge_pump_force_source, charge_pump_force_sink,
   input wire loop_running, loop_power_down_sync,
   input wire [13:0] ref_divider
);
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
wire w = wr_en && !soft_reset;
chk_tag_low:
assert property (w && wr_addr == `OFF_USER_VERSION_TAG_LOW |=> user_version_tag[7:0] == $past(wr_data)) else $error("tag byte lost");
chk_polarity_write:
assert property (w && wr_addr == `OFF_LOOP_CONTROL |=> phase_detector_invert == $past(wr_data[7])) else $error("polarity wrong");
chk_pump_current:
assert property (charge_pump_current_ua_div100 == 6 * (charge_pump_current + 1)) else $error("pump current wrong");
chk_pump_decode:
assert property ({charge_pump_high_z, charge_pump_force_source, charge_pump_force_sink} == {charge_pump_mode == 2'h0, charge_pump_mode == 2'h1, charge_pump_mode == 2'h2}) else $error("pump decode wrong");
chk_power_down:
assert property (w && wr_addr == `OFF_LOOP_CONTROL |=> loop_running == ($past(wr_data[1:0]) == 2'h0) && loop_power_down_sync == ($past(wr_data[1:0]) == 2'h3)) else $error("power-down decode wrong");
chk_ref_high:
assert property (w && wr_addr == `OFF_REF_DIVIDER_HIGH |=> ref_divider[13:8] == $past(wr_data[5:0])) else $error("divider high wrong");
chk_a_count:
assert property (w && wr_addr == `OFF_FEEDBACK_A_COUNT |=> feedback_a_count == $past(wr_data[5:0])) else $error("A count wrong");
chk_soft_defaults:
assert property (soft_reset |=> ref_divider == 14'h0001 && feedback_a_count == 6'h00 && user_version_tag == 16'h0000) else $error("defaults missing");
cover property (w && wr_addr == `OFF_LOOP_CONTROL);
cover property (soft_reset);
cover property (w && wr_addr == `OFF_REF_DIVIDER_HIGH);
endmodule
bind pll_config_registers pll_config_registers_sva i_chk (.*);

/* File: bench/pll_config_registers_test.sv */
// Self-checking bench for the loop configuration register group.
`timescale 1ns/1ns
`include "pll_config_regs.vh"
module pll_config_registers_test;
logic core_clk = 0, rst = 1, soft_reset = 0, wr_en = 0, rd_hit, phase_detector_invert;
logic [`ADDR_W-1:0] wr_addr = 0, rd_addr = 0;
logic [7:0] wr_data = 0, rd_data, d;
logic charge_pump_high_z, charge_pump_force_source, charge_pump_force_sink;
logic loop_power_down, loop_power_down_sync, loop_running;
logic [15:0] user_version_tag;
logic [2:0] charge_pump_current;
logic [5:0] charge_pump_current_ua_div100, feedback_a_count;
logic [1:0] charge_pump_mode;
logic [13:0] ref_divider;
int bad_count = 0, total_checks = 0;
pll_config_registers i_dut (.*);
always #5 core_clk = ~core_clk;
task chk(input logic [15:0] s, input logic [15:0] e);
   total_checks++;
   if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
   end
endtask
task wr(input logic [9:0] a, input logic [7:0] v);
   wr_en = 1;
   wr_addr = a;
   wr_data = v;
   @(negedge core_clk);
endtask
task rd(input logic [9:0] a, input logic [7:0] e, input logic h);
   wr_en = 0;
   rd_addr = a;
   @(negedge core_clk);
   chk({rd_hit, rd_data}, {h, e});
endtask
task stop_test;
   $display("checks %0d mismatches %0d", total_checks, bad_count);
   if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
   else $display("Run complete: FAIL");
   $finish;
endtask
initial begin
   repeat (5) @(negedge core_clk);
   rst = 0;
   rd(10'h005, 8'h00, 1); rd(10'h006, 8'h00, 1);
   rd(10'h010, 8'h7D, 1);
   rd(10'h011, 8'h01, 1); rd(10'h012, 8'h00, 1);
   rd(10'h013, 8'h00, 1);
   chk(charge_pump_current_ua_div100, 16'h0030);
   wr(10'h005, 8'hA5); wr(10'h006, 8'h3C);
   chk(user_version_tag, 16'h3CA5);
   for (int i = 0; i < 8; i++) begin
      d = {i[0], i[2:0], i[1:0], i[1:0]};
      wr(10'h010, d);
      chk({phase_detector_invert, charge_pump_current, charge_pump_mode}, d[7:2]);
      chk(charge_pump_current_ua_div100, 6 * (i + 1));
      chk({charge_pump_high_z, charge_pump_force_source, charge_pump_force_sink}, {i[1:0] == 0, i[1:0] == 1, i[1:0] == 2});
      chk({loop_running, loop_power_down, loop_power_down_sync}, {i[1:0] == 0, i[1:0] != 0, i[1:0] == 3});
   end
   wr(10'h011, 8'hFF); wr(10'h012, 8'hFF); wr(10'h013, 8'hFF); wr(10'h014, 8'h00);
   chk(ref_divider, 16'h3FFF);
   chk(feedback_a_count, 16'h003F);
   rd(10'h012, 8'h3F, 1);
   rd(10'h013, 8'h3F, 1);
   rd(10'h014, 8'h00, 0);
   soft_reset = 1;
   @(negedge core_clk);
   soft_reset = 0;
   chk(ref_divider, 16'h0001);
   chk(user_version_tag, 16'h0000);
   rd(10'h010, 8'h7D, 1);
   stop_test;
end
initial begin
   #100000;
   bad_count++;
   stop_test;
end
endmodule

/* File: rtl/config_byte.v */
// One configuration register, WIDTH bits wide (8 by default), with a per-register reset value.
`timescale 1ns/1ns
module config_byte #(
   parameter WIDTH = 8,
   parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
   input wire core_clk,
   input wire clear,
   input wire load,
   input wire [WIDTH-1:0] wr_data,
   output reg [WIDTH-1:0] value_reg
);
   always @(posedge core_clk) begin
      if (clear) begin
         value_reg <= RESET_VALUE;
      end else if (load) begin
         value_reg <= wr_data;
      end
   end
endmodule

/* File: rtl/pll_config_registers.v */
// Loop configuration register group behind the serial control port.
//
// Functional notes
// - Two bytes hold inert 16-bit version tag.
// - Bit 7 selects phase detector polarity.
// - Bits 6:4 pick pump current, 0.6-4.8 mA.
// - Bits 3:2 select pump mode, normal default.
// - Bits 1:0 select loop power-down, async default.
// - Fourteen-bit reference divider split over two registers.
// - Six-bit feedback A count in own register.
`timescale 1ns/1ns
`include "pll_config_regs.vh"
module pll_config_registers (
   input wire core_clk,
   input wire rst,
   input wire soft_reset,
   input wire wr_en,
   input wire [`ADDR_W-1:0] wr_addr,
   input wire [7:0] wr_data,
   input wire [`ADDR_W-1:0] rd_addr,
   output reg [7:0] rd_data,
   output reg rd_hit,
   output wire [15:0] user_version_tag,
   output wire phase_detector_invert,
   output wire [2:0] charge_pump_current,
   output wire [5:0] charge_pump_current_ua_div100,
   output wire [1:0] charge_pump_mode,
   output wire charge_pump_high_z,
   output wire charge_pump_force_source,
   output wire charge_pump_force_sink,
   output wire loop_power_down,
   output wire loop_power_down_sync,
   output wire loop_running,
   output wire [13:0] ref_divider,
   output wire [5:0] feedback_a_count
);
   // ==========================================================
   // Register storage
   wire clear;
   wire [7:0] tag_low;
   wire [7:0] tag_high;
   wire [7:0] loop_control_reg;
   wire [7:0] ref_low;
   wire [5:0] ref_high;
   wire [5:0] a_count;
   assign clear = rst | soft_reset;

   config_byte #(.WIDTH(8), .RESET_VALUE(`RST_USER_VERSION_TAG)) u_tag_low (
      .core_clk(core_clk),
      .clear(clear),
      .load(wr_en && wr_addr == `OFF_USER_VERSION_TAG_LOW),
      .wr_data(wr_data),
      .value_reg(tag_low)
   );
   config_byte #(.WIDTH(8), .RESET_VALUE(`RST_USER_VERSION_TAG)) u_tag_high (
      .core_clk(core_clk),
      .clear(clear),
      .load(wr_en && wr_addr == `OFF_USER_VERSION_TAG_HIGH),
      .wr_data(wr_data),
      .value_reg(tag_high)
   );
   config_byte #(.WIDTH(8), .RESET_VALUE(`RST_LOOP_CONTROL)) u_loop_control (
      .core_clk(core_clk),
      .clear(clear),
      .load(wr_en && wr_addr == `OFF_LOOP_CONTROL),
      .wr_data(wr_data),
      .value_reg(loop_control_reg)
   );
   config_byte #(.WIDTH(8), .RESET_VALUE(`RST_REF_DIVIDER_LOW)) u_ref_low (
      .core_clk(core_clk),
      .clear(clear),
      .load(wr_en && wr_addr == `OFF_REF_DIVIDER_LOW),
      .wr_data(wr_data),
      .value_reg(ref_low)
   );
   config_byte #(.WIDTH(6), .RESET_VALUE(`RST_REF_DIVIDER_HIGH)) u_ref_high (
      .core_clk(core_clk),
      .clear(clear),
      .load(wr_en && wr_addr == `OFF_REF_DIVIDER_HIGH),
      .wr_data(wr_data[5:0]),
      .value_reg(ref_high)
   );
   config_byte #(.WIDTH(6), .RESET_VALUE(`RST_FEEDBACK_A_COUNT)) u_a_count (
      .core_clk(core_clk),
      .clear(clear),
      .load(wr_en && wr_addr == `OFF_FEEDBACK_A_COUNT),
      .wr_data(wr_data[5:0]),
      .value_reg(a_count)
   );

   // ==========================================================
   // Field decode
   // The tag is only stored and read back; nothing else looks at it.
   assign user_version_tag = {tag_high, tag_low};
   assign phase_detector_invert = loop_control_reg[`POLARITY_BIT];
   assign charge_pump_current = loop_control_reg[`PUMP_CUR_MSB:`PUMP_CUR_LSB];
   // Current in units of 0.1 mA: 6 per step, code 0 gives 6 and code 7 gives 48.
   assign charge_pump_current_ua_div100 = 6'd6 * ({3'b000, charge_pump_current} + 6'd1);
   assign charge_pump_mode = loop_control_reg[`PUMP_MODE_MSB:`PUMP_MODE_LSB];
   assign charge_pump_high_z = charge_pump_mode == `PUMP_MODE_HIGH_Z;
   assign charge_pump_force_source = charge_pump_mode == `PUMP_MODE_SOURCE;
   assign charge_pump_force_sink = charge_pump_mode == `PUMP_MODE_SINK;
   // Any code other than normal keeps the loop stopped, the unused code included.
   assign loop_running = loop_control_reg[`LOOP_PD_MSB:`LOOP_PD_LSB] == `LOOP_PD_NORMAL;
   assign loop_power_down = ~loop_running;
   assign loop_power_down_sync =
      loop_control_reg[`LOOP_PD_MSB:`LOOP_PD_LSB] == `LOOP_PD_SYNC;
   assign ref_divider = {ref_high, ref_low};
   assign feedback_a_count = a_count;

   // ==========================================================
   // Readback
   always @(posedge core_clk) begin
      if (rst) begin
         rd_data <= 8'h00;
         rd_hit <= 1'b0;
      end else begin
         rd_hit <= 1'b1;
         if (rd_addr == `OFF_USER_VERSION_TAG_LOW) begin
            rd_data <= tag_low;
         end else if (rd_addr == `OFF_USER_VERSION_TAG_HIGH) begin
            rd_data <= tag_high;
         end else if (rd_addr == `OFF_LOOP_CONTROL) begin
            rd_data <= loop_control_reg;
         end else if (rd_addr == `OFF_REF_DIVIDER_LOW) begin
            rd_data <= ref_low;
         end else if (rd_addr == `OFF_REF_DIVIDER_HIGH) begin
            rd_data <= {2'b00, ref_high};
         end else if (rd_addr == `OFF_FEEDBACK_A_COUNT) begin
            rd_data <= {2'b00, a_count};
         end else begin
            rd_data <= 8'h00;
            rd_hit <= 1'b0;
         end
      end
   end
endmodule

/* File: rtl/pll_config_regs.vh */
// Register offsets, field positions, reset values and decodes of the loop configuration group.
`ifndef PLL_CONFIG_REGS_VH
`define PLL_CONFIG_REGS_VH
`define ADDR_W 10
`define OFF_USER_VERSION_TAG_LOW 10'h005
`define OFF_USER_VERSION_TAG_HIGH 10'h006
`define OFF_LOOP_CONTROL 10'h010
`define OFF_REF_DIVIDER_LOW 10'h011
`define OFF_REF_DIVIDER_HIGH 10'h012
`define OFF_FEEDBACK_A_COUNT 10'h013
`define RST_USER_VERSION_TAG 8'h00
`define RST_LOOP_CONTROL 8'h7D
`define RST_REF_DIVIDER_LOW 8'h01
`define RST_REF_DIVIDER_HIGH 6'h00
`define RST_FEEDBACK_A_COUNT 6'h00
`define POLARITY_BIT 7
`define PUMP_CUR_MSB 6
`define PUMP_CUR_LSB 4
`define PUMP_MODE_MSB 3
`define PUMP_MODE_LSB 2
`define LOOP_PD_MSB 1
`define LOOP_PD_LSB 0
`define PUMP_MODE_HIGH_Z 2'h0
`define PUMP_MODE_SOURCE 2'h1
`define PUMP_MODE_SINK 2'h2
`define PUMP_MODE_NORMAL 2'h3
`define LOOP_PD_NORMAL 2'h0
`define LOOP_PD_ASYNC 2'h1
`define LOOP_PD_UNUSED 2'h2
`define LOOP_PD_SYNC 2'h3
`endif
